//--- dv/link_receiver_tb.sv
// Testbench for the link receiver: sequence, checksum, duplicate,
// broadcast and FIFO back-pressure scenarios.
// Assumes mc_sender drives RXD; RESP_READY stays high throughout.
`timescale 1ns/10ps

module link_receiver_tb;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic OUT_READY = 1'b1;
  logic RESP_READY = 1'b1;
  logic [7:0] MY_ID = 8'h05;
  logic rxd, out_valid, resp_valid, seq_err, sum_err, dup_seen;
  logic [7:0] out_data;
  link_pkg::resp_t resp_info, last_resp;
  int err_total = 0;
  int samples_checked = 0;
  int resp_n = 0;
  int seq_n = 0;
  int sum_n = 0;
  int dup_n = 0;
  logic [7:0] got[$];

  always #25 SYS_CLK = ~SYS_CLK;

  mc_sender #(.BIT_CYC(8)) sender (.clk(SYS_CLK), .txd(rxd));

  link_receiver #(.MAX_LEN(16), .BIT_CYC(8)) uut (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .RXD(rxd), .MY_ID(MY_ID),
    .OUT_VALID(out_valid), .OUT_READY(OUT_READY), .OUT_DATA(out_data),
    .RESP_VALID(resp_valid), .RESP_READY(RESP_READY),
    .RESP_INFO(resp_info), .SEQ_ERR(seq_err), .SUM_ERR(sum_err),
    .DUP_SEEN(dup_seen));

  // --------------------------------------------------------------------
  // Monitors: pulses last one cycle, so they are counted here
  // --------------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (resp_valid === 1'b1 && RESP_READY) begin
      resp_n++;
      last_resp = resp_info;
    end
    if (out_valid === 1'b1 && OUT_READY) got.push_back(out_data);
    if (seq_err === 1'b1) seq_n++;
    if (sum_err === 1'b1) sum_n++;
    if (dup_seen === 1'b1) dup_n++;
  end

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic wait_resp(input int n);
    int k;
    for (k = 0; k < 400 && resp_n < n; k++) @(negedge SYS_CLK);
    if (resp_n < n) begin
      err_total++;
      $display("MISMATCH response wait expected %0d seen %0d", n, resp_n);
      print_verdict();
    end
  endtask : wait_resp

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_good();
    got.delete();
    sender.send_pkt(8'h05, 8'h05, 8'h02, 1'b0);
    wait_resp(1);
    repeat (6) @(negedge SYS_CLK);
    chk("resp seq", last_resp.seq_num, 8'h05);
    chk("resp dup", last_resp.dup, 1'b0);
    chk("byte count", got.size(), 2);
    chk("byte 0", got[0], 8'h05);
    chk("byte 1", got[1], 8'h06);
    $display("test good done");
  endtask : t_good

  task automatic t_dup();
    got.delete();
    sender.send_pkt(8'h05, 8'h05, 8'h02, 1'b0);
    wait_resp(2);
    repeat (6) @(negedge SYS_CLK);
    chk("dup resp seq", last_resp.seq_num, 8'h05);
    chk("dup flag", last_resp.dup, 1'b1);
    chk("dup pulses", dup_n, 1);
    chk("dup payload", got.size(), 0);
    $display("test duplicate done");
  endtask : t_dup

  task automatic t_seq_sum();
    got.delete();
    sender.send_pkt(8'h05, 8'h09, 8'h01, 1'b1);
    repeat (40) @(negedge SYS_CLK);
    chk("seq pulses", seq_n, 1);
    chk("sum pulses early", sum_n, 0);
    sender.send_pkt(8'h05, 8'h06, 8'h01, 1'b1);
    repeat (40) @(negedge SYS_CLK);
    chk("sum pulses", sum_n, 1);
    chk("bad resp count", resp_n, 2);
    chk("bad payload", got.size(), 0);
    $display("test sequence and checksum done");
  endtask : t_seq_sum

  // Ten bytes into an 8-deep FIFO with the consumer stalled
  task automatic t_fill();
    got.delete();
    OUT_READY <= 1'b0;
    sender.send_pkt(8'h05, 8'h06, 8'h0a, 1'b0);
    repeat (40) @(negedge SYS_CLK);
    chk("fifo valid", out_valid, 1'b1);
    chk("resp held", resp_n, 2);
    OUT_READY <= 1'b1;
    wait_resp(3);
    repeat (16) @(negedge SYS_CLK);
    chk("fill resp seq", last_resp.seq_num, 8'h06);
    chk("fill count", got.size(), 10);
    for (int i = 0; i < 10; i++) chk("fill byte", got[i], 8'h06 + i);
    chk("fifo empty", out_valid, 1'b0);
    $display("test fill done");
  endtask : t_fill

  task automatic t_bcast();
    got.delete();
    sender.send_pkt(8'h00, 8'h07, 8'h01, 1'b0);
    repeat (40) @(negedge SYS_CLK);
    chk("bcast no resp", resp_n, 3);
    chk("bcast count", got.size(), 1);
    chk("bcast byte", got[0], 8'h07);
    // Another device's address: nothing is shown or answered
    sender.send_pkt(8'h09, 8'h08, 8'h01, 1'b0);
    repeat (40) @(negedge SYS_CLK);
    chk("other id no resp", resp_n, 3);
    chk("other id payload", got.size(), 1);
    chk("other id seq pulses", seq_n, 1);
    $display("test broadcast done");
  endtask : t_bcast

  // Sender timeout: a missing answer forces a resend, same number
  task automatic t_retry();
    int timer;
    got.delete();
    sender.send_pkt(8'h05, 8'h08, 8'h01, 1'b1);
    timer = 0;
    while (resp_n == 3 && timer < 60) begin
      @(negedge SYS_CLK);
      timer++;
    end
    chk("retry timeout", timer, 60);
    sender.send_pkt(8'h05, 8'h08, 8'h01, 1'b0);
    wait_resp(4);
    repeat (6) @(negedge SYS_CLK);
    chk("retry resp seq", last_resp.seq_num, 8'h08);
    chk("retry dup", last_resp.dup, 1'b0);
    chk("retry count", got.size(), 1);
    chk("retry byte", got[0], 8'h08);
    chk("retry sum pulses", sum_n, 2);
    $display("test retry done");
  endtask : t_retry

  initial begin
    repeat (2) @(negedge SYS_CLK);
    RESET_N <= 1'b1;
    repeat (4) @(negedge SYS_CLK);
    chk("idle resp", resp_valid, 1'b0);
    t_good();
    t_dup();
    t_seq_sum();
    t_fill();
    t_bcast();
    t_retry();
    print_verdict();
  end
endmodule : link_receiver_tb

//--- dv/mc_sender.sv
// Sender model: the control computer that frames packets onto RXD.
// Assumes it shares the receiver's clock and uses the same BIT_CYC.
`timescale 1ns/10ps
`include "link_consts.svh"

module mc_sender #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk,
  output logic txd
);
  // Idle line is high; it only moves within a frame
  initial txd = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      txd <= fr[i];
      repeat (BIT_CYC - 1) @(negedge clk);
    end
  endtask : send_byte

  // Payload byte i is seq+i; bad flips the checksum to force an error
  task automatic send_pkt(input logic [7:0] dest, input logic [7:0] seq,
      input logic [7:0] len, input logic bad);
    logic [7:0] sum;
    sum = dest + seq + len;
    send_byte(`PACKET_SYNC_CHARACTER);
    send_byte(dest);
    send_byte(seq);
    send_byte(len);
    for (int i = 0; i < len; i++) begin
      send_byte(seq + 8'(i));
      sum = sum + seq + 8'(i);
    end
    send_byte(bad ? ~sum : sum);
  endtask : send_pkt
endmodule : mc_sender

//--- src/link_consts.svh
// Constants for the send-and-wait link receiver: framing, timing, sizes.
// Assumes a 20 MHz system clock; included by the package and the design.
`ifndef LINK_CONSTS_SVH
`define LINK_CONSTS_SVH

// ----------------------------------------------------------------------
// Framing
// ----------------------------------------------------------------------
`define PACKET_SYNC_CHARACTER 8'h16
`define BROADCAST_ID 8'h00
`define MAX_PAYLOAD 16
`define FIFO_DEPTH 8

// ----------------------------------------------------------------------
// Serial timing
// ----------------------------------------------------------------------
`define CLK_HZ 20000000
`define BAUD_RATE 9600
`define DATA_BITS 8
`define STOP_BITS 1
`define BIT_CYC (`CLK_HZ / `BAUD_RATE)
`define HALF_BIT_CYC (`BIT_CYC / 2)

`endif

//--- src/link_pkg.sv
// Types shared by the link receiver and its testbench.
// Assumes link_consts.svh sits on the include path.
`include "link_consts.svh"

package link_pkg;

  // Answer to hand to the response transmitter
  typedef struct packed {
    logic [7:0] seq_num;
    logic dup;
  } resp_t;

  typedef enum logic [1:0] {
    U_IDLE = 2'h0,
    U_START = 2'h1,
    U_DATA = 2'h3,
    U_STOP = 2'h2
  } uart_st_t;

  typedef enum logic [3:0] {
    P_SYNC = 4'h0,
    P_DEST = 4'h1,
    P_SEQ = 4'h3,
    P_LEN = 4'h2,
    P_DATA = 4'h6,
    P_SUM = 4'h7,
    P_EVAL = 4'h5,
    P_PUSH = 4'h4,
    P_RESP = 4'hc
  } pkt_st_t;

  typedef struct packed {
    logic [1:0] rxs;
    uart_st_t ust;
    logic [11:0] bcnt;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic byte_vld;
    pkt_st_t pst;
    logic [7:0] dest;
    logic [7:0] seq_num;
    logic [7:0] len;
    logic [7:0] sum;
    logic [7:0] cks;
    logic [7:0] idx;
    logic bcast;
    logic have_last;
    logic [7:0] last_seq;
    resp_t resp;
    logic seq_err;
    logic sum_err;
    logic dup_seen;
  } rx_state_t;

endpackage : link_pkg

//--- src/link_receiver.sv
// Send-and-wait link receiver: serial byte receiver, packet checker,
// payload buffer and output FIFO.
// Assumes RXD comes from a pin, MY_ID is steady configuration logic on
// SYS_CLK, and a response transmitter drains the RESP handshake.
//
// Function
// - One packet outstanding; sender awaits response
// - Check sequence number before the checksum
// - Checksum covers all but sync, checksum
// - Matching checksum: act and acknowledge
// - Duplicate: acknowledge but do not execute
// - Serial link 9600 baud, 8N1, changeable
// - Broadcast id zero accepted, never answered
`timescale 1ns/10ps
`include "link_consts.svh"

// ----------------------------------------------------------------------
// Byte FIFO
// ----------------------------------------------------------------------
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage needs no reset; only slots holding a pushed byte are ever popped
  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wp] <= in_data;
    end
  end

  // A refused push must leave count and write pointer alone
  chk_fifo_full_refuse: assert property (
    @(posedge clk) disable iff (!rst_n)
    (q.cnt == (AW+1)'(DEPTH) && in_valid && !out_ready)
    |=> q.cnt == (AW+1)'(DEPTH) && $stable(q.wp))
    else $error("fifo accepts while full");

  chk_fifo_data_held: assert property (
    @(posedge clk) disable iff (!rst_n)
    (out_valid && !out_ready) |=> out_valid && $stable(out_data))
    else $error("fifo output changed while stalled");
endmodule : byte_fifo

// ----------------------------------------------------------------------
// Receiver top
// ----------------------------------------------------------------------
module link_receiver #(
  parameter int MAX_LEN = `MAX_PAYLOAD,
  parameter int BIT_CYC = `BIT_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic RXD,
  input wire logic [7:0] MY_ID,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [7:0] OUT_DATA,
  output logic RESP_VALID,
  input wire logic RESP_READY,
  output link_pkg::resp_t RESP_INFO,
  output logic SEQ_ERR,
  output logic SUM_ERR,
  output logic DUP_SEEN
);
  localparam int IW = $clog2(MAX_LEN);
  localparam logic [11:0] BIT_LD = 12'(BIT_CYC - 1);
  localparam logic [11:0] HALF_LD = 12'(BIT_CYC / 2 - 1);
  localparam int BIT_LAST = `DATA_BITS - 1;

  link_pkg::rx_state_t q, d;
  logic [7:0] payload [MAX_LEN];
  logic pay_we;
  logic fifo_valid;
  logic fifo_ready;
  logic rx;
  logic addressed, seq_new, seq_dup;

  assign rx = q.rxs[1];
  assign pay_we = q.byte_vld && (q.pst == link_pkg::P_DATA);
  assign fifo_valid = (q.pst == link_pkg::P_PUSH);
  assign addressed = (q.dest == MY_ID) || (q.dest == `BROADCAST_ID);
  assign seq_dup = q.have_last && (q.seq_num == q.last_seq);
  assign seq_new = !q.have_last || (q.seq_num == q.last_seq + 8'h01);

  always_comb begin
    d = q;
    d.byte_vld = 1'b0;
    d.seq_err = 1'b0;
    d.sum_err = 1'b0;
    d.dup_seen = 1'b0;
    // Second flop alone reads the first
    d.rxs = {q.rxs[0], RXD};
    // ------------------------------------------------------------------
    // Serial byte receiver, 8 data bits, 1 stop bit, no parity
    // ------------------------------------------------------------------
    unique case (q.ust)
      link_pkg::U_IDLE: begin
        if (!rx) begin
          d.ust = link_pkg::U_START;
          d.bcnt = HALF_LD;
        end
      end
      link_pkg::U_START: begin
        if (q.bcnt != '0) begin
          d.bcnt = q.bcnt - 12'h001;
        end else if (!rx) begin
          d.ust = link_pkg::U_DATA;
          d.bcnt = BIT_LD;
          d.bitn = '0;
        end else begin
          d.ust = link_pkg::U_IDLE; // Glitch, not a start bit
        end
      end
      link_pkg::U_DATA: begin
        if (q.bcnt != '0) begin
          d.bcnt = q.bcnt - 12'h001;
        end else begin
          d.shreg = {rx, q.shreg[7:1]};
          d.bcnt = BIT_LD;
          if (q.bitn == 3'(BIT_LAST)) begin
            d.ust = link_pkg::U_STOP;
          end else begin
            d.bitn = q.bitn + 3'h1;
          end
        end
      end
      link_pkg::U_STOP: begin
        if (q.bcnt != '0) begin
          d.bcnt = q.bcnt - 12'h001;
        end else begin
          d.ust = link_pkg::U_IDLE;
          // A byte with a bad stop bit is dropped; the sender retries
          d.byte_vld = rx;
        end
      end
    endcase
    // ------------------------------------------------------------------
    // Packet checker
    // ------------------------------------------------------------------
    unique case (q.pst)
      link_pkg::P_SYNC: begin
        if (q.byte_vld && q.shreg == `PACKET_SYNC_CHARACTER) begin
          d.pst = link_pkg::P_DEST;
          d.sum = 8'h00;
        end
      end
      link_pkg::P_DEST: begin
        if (q.byte_vld) begin
          d.dest = q.shreg;
          d.sum = q.sum + q.shreg;
          d.pst = link_pkg::P_SEQ;
        end
      end
      link_pkg::P_SEQ: begin
        if (q.byte_vld) begin
          d.seq_num = q.shreg;
          d.sum = q.sum + q.shreg;
          d.pst = link_pkg::P_LEN;
        end
      end
      link_pkg::P_LEN: begin
        if (q.byte_vld) begin
          d.len = q.shreg;
          d.sum = q.sum + q.shreg;
          d.idx = 8'h00;
          if (q.shreg > 8'(MAX_LEN)) begin
            d.pst = link_pkg::P_SYNC;
          end else if (q.shreg == 8'h00) begin
            d.pst = link_pkg::P_SUM;
          end else begin
            d.pst = link_pkg::P_DATA;
          end
        end
      end
      link_pkg::P_DATA: begin
        if (q.byte_vld) begin
          d.sum = q.sum + q.shreg;
          d.idx = q.idx + 8'h01;
          if (q.idx == q.len - 8'h01) begin
            d.pst = link_pkg::P_SUM;
          end
        end
      end
      link_pkg::P_SUM: begin
        if (q.byte_vld) begin
          d.cks = q.shreg;
          d.pst = link_pkg::P_EVAL;
        end
      end
      link_pkg::P_EVAL: begin
        d.pst = link_pkg::P_SYNC;
        d.idx = 8'h00;
        d.bcast = (q.dest == `BROADCAST_ID);
        if (addressed) begin
          if (!(seq_new || seq_dup)) begin
            d.seq_err = 1'b1;
          end else if (q.sum != q.cks) begin
            d.sum_err = 1'b1;
          end else begin
            d.resp.seq_num = q.seq_num;
            d.resp.dup = seq_dup;
            if (seq_dup) begin
              // Answered again, payload dropped
              d.dup_seen = 1'b1;
              if (q.dest != `BROADCAST_ID) begin
                d.pst = link_pkg::P_RESP;
              end
            end else begin
              d.have_last = 1'b1;
              d.last_seq = q.seq_num;
              if (q.len != 8'h00) begin
                d.pst = link_pkg::P_PUSH;
              end else if (q.dest != `BROADCAST_ID) begin
                d.pst = link_pkg::P_RESP;
              end
            end
          end
        end
      end
      link_pkg::P_PUSH: begin
        // Back-pressure holds the answer until the last payload byte enters the FIFO
        if (fifo_ready) begin
          d.idx = q.idx + 8'h01;
          if (q.idx == q.len - 8'h01) begin
            d.pst = q.bcast ? link_pkg::P_SYNC : link_pkg::P_RESP;
          end
        end
      end
      link_pkg::P_RESP: begin
        // Bytes seen while waiting are ignored: one packet in flight
        if (RESP_READY) begin
          d.pst = link_pkg::P_SYNC;
        end
      end
      default: begin
        d.pst = link_pkg::P_SYNC;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q <= '0;
      q.rxs <= 2'h3;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (pay_we) begin
      payload[q.idx[IW-1:0]] <= q.shreg;
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) out_fifo (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(payload[q.idx[IW-1:0]]),
    .out_valid(OUT_VALID),
    .out_ready(OUT_READY),
    .out_data(OUT_DATA)
  );

  assign RESP_VALID = (q.pst == link_pkg::P_RESP);
  assign RESP_INFO = q.resp;
  assign SEQ_ERR = q.seq_err;
  assign SUM_ERR = q.sum_err;
  assign DUP_SEEN = q.dup_seen;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  chk_seq_checked_first: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (q.pst == link_pkg::P_EVAL && addressed && !seq_new && !seq_dup)
    |=> SEQ_ERR && !SUM_ERR && q.pst == link_pkg::P_SYNC)
    else $error("out-of-sequence packet not dropped first");

  chk_sum_mismatch_drop: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (q.pst == link_pkg::P_EVAL && addressed && (seq_new || seq_dup)
     && q.sum != q.cks) |=> SUM_ERR ##1 !RESP_VALID && !fifo_valid)
    else $error("bad checksum accepted");

  chk_good_acked: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (q.pst == link_pkg::P_EVAL && q.dest == MY_ID && MY_ID != 8'h00
     && seq_new && q.sum == q.cks) |-> ##[1:300] RESP_VALID)
    else $error("good packet never acknowledged");

  chk_dup_not_run: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (q.pst == link_pkg::P_EVAL && q.dest == MY_ID && MY_ID != 8'h00
     && seq_dup && q.sum == q.cks)
    |=> RESP_VALID && RESP_INFO.dup && DUP_SEEN && !fifo_valid)
    else $error("duplicate executed or not answered");

  chk_bcast_silent: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (q.pst == link_pkg::P_EVAL && q.dest == 8'h00)
    |=> !RESP_VALID [*8])
    else $error("broadcast answered");

  chk_resp_held: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (RESP_VALID && !RESP_READY) |=> RESP_VALID && $stable(RESP_INFO))
    else $error("response dropped before taken");

  chk_bit_period: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (q.ust == link_pkg::U_DATA && q.bcnt == 12'h000)
    |=> q.bcnt == BIT_LD ##1 q.bcnt == BIT_LD - 12'h001)
    else $error("bit period reload wrong");
endmodule : link_receiver
